//--- logic/bcs_supervisor.sv
// breaker open/close supervision, wear counter and reclose counters
`include "bcs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module bcs_supervisor #(
  parameter int WAIT_CYC = `BCS_WAIT_CYC,
  parameter int ALARM_CYC = `BCS_ALARM_CYC,
  parameter int LEN_W = 24,
  parameter int WEAR_W = 16,
  parameter int CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_breaker_position_input,
  input wire logic i_close_inhibit_input,
  input wire logic i_sync_ok_input,
  input wire logic i_reclose_inhibit_input,
  input wire logic [3:0] i_initiation_lines,
  input wire logic i_reclose_active,
  output logic o_breaker_open_cmd,
  output logic o_breaker_close_cmd,
  output logic o_breaker_failure_alarm,
  output logic o_reclose_abort,
  output logic o_reclose_blocked
);
  localparam int CW = 32;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    bcs_pkg::bcs_state_e st;
    bcs_pkg::bcs_ctrl_s ctrl;
    logic [LEN_W-1:0] open_len;
    logic [LEN_W-1:0] close_len;
    logic [WEAR_W-1:0] wear;
    logic [WEAR_W-1:0] prealarm;
    logic [4:0][7:0] weight;
    logic [CW-1:0] tmr;
    logic [CW-1:0] alarm_tmr;
    logic zero_alarm;
    logic pos_q;
    logic pos_start;
    logic close_pending;
    logic sync_wait;
    logic [CW-1:0] sync_tmr;
    logic [CNT_W-1:0] shots;
    logic [CNT_W-1:0] good;
    logic [2:0] cause;
    bcs_pkg::bcs_out_s out;
    logic blocked;
    logic [31:0] rdata;
  } bcs_state_s;

  bcs_state_s r;
  bcs_state_s next_r;

  logic zero_blk;
  logic close_ok;
  logic opening_seen;
  logic [7:0] dec;
  logic [WEAR_W:0] diff;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // position high means breaker closed
  always_comb begin
    next_r = r;
    next_r.pos_q = i_breaker_position_input;
    next_r.out.reclose_abort = 1'b0;
    zero_blk = r.ctrl.zero_count_close_block_select && (r.wear == '0);
    close_ok = !i_breaker_position_input && (i_initiation_lines == 4'h0) &&
               !i_close_inhibit_input && !zero_blk &&
               (!r.ctrl.sync_check_on || i_sync_ok_input);
    opening_seen = r.pos_q && !i_breaker_position_input;
    // cause of opening picks the weight; lowest line wins
    dec = r.weight[4];
    for (int k = 3; k >= 0; k--) begin
      if (i_initiation_lines[k]) begin
        dec = r.weight[k];
      end
    end
    diff = {1'b0, r.wear} - {{(WEAR_W-8){1'b0}}, 1'b0, dec};
    // alarm pulse timer
    if (r.alarm_tmr != '0) begin
      next_r.alarm_tmr = r.alarm_tmr - 1'b1;
    end
    // wear counter on openings
    if (opening_seen && dec != 8'h0) begin
      next_r.wear = diff[WEAR_W] ? '0 : diff[WEAR_W-1:0];
      if (r.prealarm != '0 && !diff[WEAR_W] && diff[WEAR_W-1:0] <= r.prealarm) begin
        next_r.alarm_tmr = CW'(ALARM_CYC);
      end
    end
    if (next_r.wear == '0) begin
      next_r.zero_alarm = 1'b1;
    end
    // sync wait after dead time
    if (r.sync_wait) begin
      if (i_sync_ok_input) begin
        next_r.sync_wait = 1'b0;
      end else if (r.sync_tmr == '0) begin
        next_r.sync_wait = 1'b0;
        next_r.out.reclose_abort = 1'b1;
        next_r.alarm_tmr = CW'(ALARM_CYC);
      end else begin
        next_r.sync_tmr = r.sync_tmr - 1'b1;
      end
    end
    // command sequencer
    unique case (r.st)
      bcs_pkg::BCS_IDLE: begin
        next_r.out.breaker_open_cmd = 1'b0;
        next_r.out.breaker_close_cmd = 1'b0;
      end
      bcs_pkg::BCS_WAIT_CLOSE: begin
        if (close_ok) begin
          next_r.st = bcs_pkg::BCS_CLOSING;
          next_r.tmr = CW'(r.close_len);
          next_r.pos_start = i_breaker_position_input;
          next_r.out.breaker_close_cmd = 1'b1;
        end else if (r.tmr == '0) begin
          next_r.st = bcs_pkg::BCS_IDLE;
          next_r.alarm_tmr = CW'(ALARM_CYC);
          next_r.out.reclose_abort = 1'b1;
        end else begin
          next_r.tmr = r.tmr - 1'b1;
        end
      end
      bcs_pkg::BCS_OPENING,
      bcs_pkg::BCS_CLOSING: begin
        if (r.ctrl.feedback_on && i_breaker_position_input != r.pos_start) begin
          next_r.st = bcs_pkg::BCS_IDLE;
          next_r.out.breaker_open_cmd = 1'b0;
          next_r.out.breaker_close_cmd = 1'b0;
        end else if (r.tmr <= CW'(1)) begin
          next_r.st = bcs_pkg::BCS_IDLE;
          next_r.out.breaker_open_cmd = 1'b0;
          next_r.out.breaker_close_cmd = 1'b0;
          if (r.ctrl.feedback_on) begin
            next_r.alarm_tmr = CW'(ALARM_CYC);
            next_r.out.reclose_abort = 1'b1;
          end
        end else begin
          next_r.tmr = r.tmr - 1'b1;
        end
      end
    endcase
    if (i_reclose_inhibit_input) begin
      next_r.sync_wait = 1'b0;
      next_r.out.reclose_abort = 1'b1;
    end
    next_r.blocked = zero_blk || i_reclose_inhibit_input;
    // register writes; commands start pulses
    if (i_wr) begin
      if (i_addr == `BCS_ADDR_CTRL) begin
        // field by field: packed member order would put feedback on bit 2
        next_r.ctrl.feedback_on = i_wdata[`BCS_CTRL_FB_BIT];
        next_r.ctrl.zero_count_close_block_select = i_wdata[`BCS_CTRL_ZBLK_BIT];
        next_r.ctrl.sync_check_on = i_wdata[`BCS_CTRL_SYNC_BIT];
      end
      if (i_addr == `BCS_ADDR_OPEN_LEN) begin
        next_r.open_len = i_wdata[LEN_W-1:0];
      end
      if (i_addr == `BCS_ADDR_CLOSE_LEN) begin
        next_r.close_len = i_wdata[LEN_W-1:0];
      end
      if (i_addr == `BCS_ADDR_WEAR) begin
        next_r.wear = i_wdata[WEAR_W-1:0];
        next_r.zero_alarm = (i_wdata[WEAR_W-1:0] == '0);
      end
      if (i_addr == `BCS_ADDR_PREALARM) begin
        next_r.prealarm = i_wdata[WEAR_W-1:0];
      end
      for (int k = 0; k < 5; k++) begin
        if (i_addr == `BCS_ADDR_W_LINE1 + 4'(k)) begin
          next_r.weight[k] = (i_wdata[7:0] > `BCS_WEIGHT_MAX) ? `BCS_WEIGHT_MAX : i_wdata[7:0];
        end
      end
      if (i_addr == `BCS_ADDR_CMD) begin
        if (i_wdata[`BCS_CMD_SHOT_BIT]) begin
          next_r.shots = r.shots + 1'b1;
        end
        if (i_wdata[`BCS_CMD_GOOD_BIT]) begin
          next_r.good = r.good + 1'b1;
        end
        if (i_wdata[`BCS_CMD_DEAD_END_BIT] && r.ctrl.sync_check_on) begin
          next_r.sync_wait = 1'b1;
          next_r.sync_tmr = CW'(WAIT_CYC);
        end
        if (i_wdata[`BCS_CMD_OPEN_BIT]) begin
          next_r.st = bcs_pkg::BCS_OPENING;
          next_r.tmr = CW'(r.open_len);
          next_r.pos_start = i_breaker_position_input;
          next_r.out.breaker_open_cmd = 1'b1;
          next_r.out.breaker_close_cmd = 1'b0;
        end else if (i_wdata[`BCS_CMD_CLOSE_BIT] && r.st == bcs_pkg::BCS_IDLE &&
                     !(i_wdata[`BCS_CMD_SHOT_BIT] && r.blocked)) begin
          next_r.st = bcs_pkg::BCS_WAIT_CLOSE;
          next_r.tmr = CW'(WAIT_CYC);
        end
      end
    end
    // readback, answered in the cycle after the strobe
    next_r.rdata = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        `BCS_ADDR_CTRL: next_r.rdata = {29'h0, r.ctrl.sync_check_on,
                                        r.ctrl.zero_count_close_block_select,
                                        r.ctrl.feedback_on};
        `BCS_ADDR_OPEN_LEN: next_r.rdata = 32'(r.open_len);
        `BCS_ADDR_CLOSE_LEN: next_r.rdata = 32'(r.close_len);
        `BCS_ADDR_WEAR: next_r.rdata = 32'(r.wear);
        `BCS_ADDR_PREALARM: next_r.rdata = 32'(r.prealarm);
        `BCS_ADDR_STATUS: next_r.rdata = {26'h0, r.blocked, r.sync_wait, r.zero_alarm,
                                          r.st, r.out.breaker_failure_alarm};
        `BCS_ADDR_SHOTS: next_r.rdata = 32'(r.shots);
        `BCS_ADDR_GOOD: next_r.rdata = 32'(r.good);
        default: begin
          if (i_addr >= `BCS_ADDR_W_LINE1 && i_addr <= `BCS_ADDR_W_MANUAL) begin
            next_r.rdata = {24'h0, r.weight[3'(i_addr - `BCS_ADDR_W_LINE1)]};
          end
        end
      endcase
    end
    // zero count alarm is level, others are 0.2 s pulses
    next_r.out.breaker_failure_alarm = next_r.zero_alarm || (next_r.alarm_tmr != '0);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.wear <= {WEAR_W{1'b1}};
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_breaker_open_cmd = r.out.breaker_open_cmd;
  assign o_breaker_close_cmd = r.out.breaker_close_cmd;
  assign o_breaker_failure_alarm = r.out.breaker_failure_alarm;
  assign o_reclose_abort = r.out.reclose_abort;
  assign o_reclose_blocked = r.blocked;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence close_starts;
    !o_breaker_close_cmd ##1 o_breaker_close_cmd;
  endsequence
  sequence fb_change;
    r.ctrl.feedback_on && (o_breaker_open_cmd || o_breaker_close_cmd) &&
    (i_breaker_position_input != r.pos_start);
  endsequence

  cmd_exclusive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(o_breaker_open_cmd && o_breaker_close_cmd)) else $error("open and close together");
  close_inhibit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    close_starts |-> $past(!i_close_inhibit_input)) else $error("close under inhibit");
  close_pre_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    close_starts |-> $past(!i_breaker_position_input && i_initiation_lines == 4'h0))
    else $error("close without preconditions");
  pulse_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fb_change |=> !(o_breaker_open_cmd || o_breaker_close_cmd)) else $error("pulse not ended");
  zero_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r.wear == '0 && !i_wr) |=> o_breaker_failure_alarm) else $error("zero wear without alarm");
  wear_sat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (opening_seen && !i_wr) |=> r.wear <= $past(r.wear)) else $error("wear wrapped");
  zero_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r.ctrl.zero_count_close_block_select && r.wear == '0 && !i_wr) |=> o_reclose_blocked)
    else $error("zero wear not blocking");
  inhibit_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_reclose_inhibit_input |=> o_reclose_abort) else $error("inhibit did not abort");
  wait_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r.st == bcs_pkg::BCS_WAIT_CLOSE && r.tmr == '0 && !close_ok && !i_wr)
    |=> o_breaker_failure_alarm && o_reclose_abort) else $error("close wait not abandoned");

  // ------------------------------------------------------------
  // pulse end, failure, wear, sync, inhibit and counter checks
  // ------------------------------------------------------------
  // last counted cycle of a command pulse, no bus write beside it
  sequence pulse_last;
    (r.st == bcs_pkg::BCS_OPENING || r.st == bcs_pkg::BCS_CLOSING) &&
    (r.tmr <= CW'(1)) && !i_wr;
  endsequence
  // position never moved while feedback is watched
  sequence pos_unmoved;
    r.ctrl.feedback_on && (i_breaker_position_input == r.pos_start);
  endsequence

  // a pulse never outlives its configured length
  pulse_max_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pulse_last |=> !(o_breaker_open_cmd || o_breaker_close_cmd))
    else $error("pulse too long");

  // seized breaker: alarm now and drop the running sequence
  fail_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pulse_last ##0 pos_unmoved |=> o_breaker_failure_alarm && o_reclose_abort)
    else $error("failed operation not flagged");

  // without feedback nothing judges the outcome
  nofb_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pulse_last ##0 (!r.ctrl.feedback_on && !i_reclose_inhibit_input && !r.sync_wait)
    |=> !o_reclose_abort) else $error("unsupervised pulse judged");

  // a new pulsed alarm always starts with its full length loaded
  alarm_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($rose(o_breaker_failure_alarm) && !r.zero_alarm) |-> r.alarm_tmr == CW'(ALARM_CYC))
    else $error("alarm pulse short");

  // the pulse stays up until its timer runs out
  alarm_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r.alarm_tmr > CW'(1)) |=> o_breaker_failure_alarm) else $error("alarm pulse cut");

  // opening that lands at or under the pre-alarm level
  prealarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (opening_seen && dec != 8'h0 && r.prealarm != '0 && !diff[WEAR_W] &&
     diff[WEAR_W-1:0] <= r.prealarm && !i_wr) |=> o_breaker_failure_alarm)
    else $error("pre-alarm missing");

  // each opening that does not underflow takes exactly the weight of its cause
  wear_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (opening_seen && dec != 8'h0 && !diff[WEAR_W] && !i_wr) |=>
    r.wear == $past(r.wear) - WEAR_W'($past(dec))) else $error("wrong wear step");

  // zero weight leaves the counter alone
  weights_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (dec == 8'h0 && !i_wr) |=> r.wear == $past(r.wear)) else $error("wear moved");

  // reloading a nonzero count clears the permanent alarm
  reload_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == `BCS_ADDR_WEAR && i_wdata[WEAR_W-1:0] != '0) |=> !r.zero_alarm)
    else $error("zero alarm kept");

  // no sync in time: lock out and alarm
  sync_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r.sync_wait && !i_sync_ok_input && r.sync_tmr == '0 && !i_wr) |=>
    !r.sync_wait && o_reclose_abort && o_breaker_failure_alarm)
    else $error("sync wait not locked out");

  // reclose inhibit blocks from the next cycle on
  inhibit_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_reclose_inhibit_input |=> o_reclose_blocked) else $error("inhibit not blocking");

  // shot and success counters step by one per command
  shot_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == `BCS_ADDR_CMD && i_wdata[`BCS_CMD_SHOT_BIT]) |=>
    r.shots == CNT_W'($past(r.shots) + 1'b1)) else $error("shot count wrong");
  good_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == `BCS_ADDR_CMD && i_wdata[`BCS_CMD_GOOD_BIT]) |=>
    r.good == CNT_W'($past(r.good) + 1'b1)) else $error("success count wrong");
endmodule // bcs_supervisor
`default_nettype wire

//--- logic/bcs_consts.svh
// constants for the breaker control supervisor
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_CLK_HZ 25000000
`define BCS_WAIT_MS 2000
`define BCS_WAIT_CYC ((`BCS_CLK_HZ / 1000) * `BCS_WAIT_MS)
`define BCS_ALARM_MS 200
`define BCS_ALARM_CYC ((`BCS_CLK_HZ / 1000) * `BCS_ALARM_MS)
`define BCS_WEIGHT_MAX 8'h32
`define BCS_ADDR_CTRL 4'h0
`define BCS_ADDR_OPEN_LEN 4'h1
`define BCS_ADDR_CLOSE_LEN 4'h2
`define BCS_ADDR_WEAR 4'h3
`define BCS_ADDR_PREALARM 4'h4
`define BCS_ADDR_W_LINE1 4'h5
`define BCS_ADDR_W_MANUAL 4'h9
`define BCS_ADDR_CMD 4'ha
`define BCS_ADDR_STATUS 4'hb
`define BCS_ADDR_SHOTS 4'hc
`define BCS_ADDR_GOOD 4'hd
`define BCS_CTRL_FB_BIT 0
`define BCS_CTRL_ZBLK_BIT 1
`define BCS_CTRL_SYNC_BIT 2
`define BCS_CMD_OPEN_BIT 0
`define BCS_CMD_CLOSE_BIT 1
`define BCS_CMD_MANUAL_BIT 2
`define BCS_CMD_SHOT_BIT 3
`define BCS_CMD_GOOD_BIT 4
`define BCS_CMD_DEAD_END_BIT 5
`endif

//--- logic/bcs_pkg.sv
// types for the breaker control supervisor
package bcs_pkg;
  typedef enum logic [1:0] {
    BCS_IDLE = 2'b00,
    BCS_OPENING = 2'b01,
    BCS_WAIT_CLOSE = 2'b10,
    BCS_CLOSING = 2'b11
  } bcs_state_e;
  typedef struct packed {
    logic feedback_on;
    logic zero_count_close_block_select;
    logic sync_check_on;
  } bcs_ctrl_s;
  typedef struct packed {
    logic breaker_open_cmd;
    logic breaker_close_cmd;
    logic breaker_failure_alarm;
    logic reclose_abort;
  } bcs_out_s;
endpackage

//--- testbench/bcs_breaker_model.sv
// behavioural breaker drive with auxiliary position contact
`timescale 1ns/100ps
`default_nettype none
module bcs_breaker_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_open,
  input wire logic i_close,
  input wire logic i_stuck,
  output logic o_pos
);
  logic [1:0] cnt;
  // contacts move on the third edge of a command; stuck models a seized mechanism
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 2'h0;
      o_pos <= 1'b1;
    end else if (!i_stuck && ((i_open && o_pos) || (i_close && !o_pos))) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h2) begin
        o_pos <= !o_pos;
      end
    end else begin
      cnt <= 2'h0;
    end
  end
endmodule // bcs_breaker_model
`default_nettype wire

//--- testbench/breaker_control_supervisor_test.sv
// self-checking bench for the breaker control supervisor
`timescale 1ns/100ps
`default_nettype none
module breaker_control_supervisor_test;
  logic clk, rst_n, wr, rd, pos, close_inhibit_input, sync, rinh, stuck;
  logic ocmd, ccmd, alarm, abort, blocked;
  logic [3:0] addr, lines;
  logic [31:0] wdata, rdata, d;
  int miscompares, samples_checked, w;
  int n [4];
  int b [4];
  // short waits so the 2 s and 0.2 s figures fit the run
  bcs_supervisor #(.WAIT_CYC(100), .ALARM_CYC(20)) uut (.i_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_breaker_position_input(pos), .i_close_inhibit_input(close_inhibit_input),
    .i_sync_ok_input(sync), .i_reclose_inhibit_input(rinh),
    .i_initiation_lines(lines), .i_reclose_active(1'b0),
    .o_breaker_open_cmd(ocmd), .o_breaker_close_cmd(ccmd),
    .o_breaker_failure_alarm(alarm), .o_reclose_abort(abort),
    .o_reclose_blocked(blocked));
  bcs_breaker_model far (.i_clk(clk), .i_rst_n(rst_n), .i_open(ocmd),
    .i_close(ccmd), .i_stuck(stuck), .o_pos(pos));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // high cycles of each output, so pulse lengths are deltas
  always @(posedge clk) begin
    if (ocmd === 1'b1) n[0]++;
    if (ccmd === 1'b1) n[1]++;
    if (alarm === 1'b1) n[2]++;
    if (abort === 1'b1) n[3]++;
    if (ocmd === 1'b1 && ccmd === 1'b1) chk("both cmds", 1, 0);
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  function automatic int dl(input int i);
    return n[i] - b[i];
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string s, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(s, rdata, e);
  endtask
  // bounded wait for open (0), close (1) or alarm (2) to rise
  task automatic wrise(input int s);
    w = 0;
    while ((s == 0 ? ocmd : s == 1 ? ccmd : alarm) !== 1'b1 && w < 300) begin
      @(posedge clk);
      #1;
      w++;
    end
  endtask
  // command write, then let pulses and alarms run out
  task automatic cmd(input logic [31:0] v, input int k);
    b = n;
    wreg(4'ha, v);
    cyc(k);
  endtask
  task automatic t_reset;
    rchk("wear rst", 4'h3, 32'h0000ffff);
    rchk("status rst", 4'hb, 32'h0);
    rchk("unmapped", 4'hf, 32'h0);
  endtask
  task automatic t_nofb;
    wreg(4'h1, 32'ha);
    wreg(4'h2, 32'ha);
    stuck <= 1'b1;
    cmd(32'h5, 40);
    chk("open exact", dl(0), 10);
    chk("no check", dl(2), 0);
    stuck <= 1'b0;
  endtask
  task automatic t_fb;
    wreg(4'h0, 32'h1);
    wreg(4'h9, 32'h7);
    wreg(4'h6, 32'h3);
    cmd(32'h5, 40);
    chk("open early", 32'(dl(0) < 10), 1);
    chk("no alarm", dl(2), 0);
    rchk("wear manual", 4'h3, 32'h0000fff8);
    cmd(32'h2, 40);
    chk("close early", 32'(dl(1) < 10), 1);
    rchk("wear close", 4'h3, 32'h0000fff8);
    lines <= 4'b0110;
    cmd(32'h1, 40);
    lines <= 4'h0;
    rchk("wear line2", 4'h3, 32'h0000fff5);
    cmd(32'h2, 40);
  endtask
  task automatic t_fail;
    stuck <= 1'b1;
    cmd(32'h1, 60);
    chk("open full", dl(0), 10);
    chk("alarm len", dl(2), 20);
    chk("abort", dl(3), 1);
    stuck <= 1'b0;
    cmd(32'h5, 40);
  endtask
  task automatic t_inhibit;
    close_inhibit_input <= 1'b1;
    cmd(32'h2, 0);
    wrise(2);
    chk("wait abandon", 32'(w > 94 && w < 106), 1);
    cyc(40);
    chk("inhibited", dl(1), 0);
    close_inhibit_input <= 1'b0;
  endtask
  task automatic t_r3;
    wreg(4'h0, 32'h0);
    stuck <= 1'b1;
    cmd(32'h2, 0);
    wrise(1);
    wreg(4'ha, 32'h1);
    cyc(1);
    #1;
    chk("open wins", {ocmd, ccmd}, 2'b10);
    cyc(40);
    wreg(4'h0, 32'h1);
    stuck <= 1'b0;
    cmd(32'h2, 0);
    wrise(1);
    chk("close prompt", 32'(w < 5), 1);
    cyc(40);
  endtask
  task automatic t_wear;
    wreg(4'h0, 32'h3);
    wreg(4'h4, 32'h6);
    wreg(4'h3, 32'hd);
    cmd(32'h5, 40);
    chk("prealarm", dl(2), 20);
    cmd(32'h2, 40);
    cmd(32'h5, 40);
    rchk("wear sat", 4'h3, 32'h0);
    chk("zero alarm", alarm, 1);
    chk("zero block", blocked, 1);
    cmd(32'h2, 40);
    chk("zero no close", dl(1), 0);
    wreg(4'h3, 32'h64);
    cyc(2);
    #1;
    chk("reload", {alarm, blocked}, 2'b00);
    wreg(4'h4, 32'h0);
    cmd(32'h2, 40);
    cmd(32'h5, 40);
    chk("pre off", dl(2), 0);
  endtask
  task automatic t_reclose;
    wreg(4'ha, 32'h8);
    wreg(4'ha, 32'h8);
    wreg(4'ha, 32'h10);
    rchk("shots", 4'hc, 32'h2);
    rchk("good", 4'hd, 32'h1);
    wreg(4'h0, 32'h5);
    cmd(32'h20, 0);
    wrise(2);
    chk("sync wait", 32'(w > 94 && w < 106), 1);
    cyc(40);
    chk("sync lockout", 32'(dl(3) > 0), 1);
    b = n;
    rinh <= 1'b1;
    cyc(3);
    #1;
    chk("inh block", blocked, 1);
    chk("inh abort", 32'(dl(3) > 0), 1);
    rinh <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    cyc(5000);
    miscompares++;
    test_done;
  end
  initial begin
    {rst_n, wr, rd, close_inhibit_input, sync, rinh, stuck} = '0;
    addr = 4'h0;
    wdata = 32'h0;
    lines = 4'h0;
    cyc(8);
    rst_n <= 1'b1;
    t_reset;
    t_nofb;
    t_fb;
    t_fail;
    t_inhibit;
    t_r3;
    t_wear;
    t_reclose;
    test_done;
  end
endmodule // breaker_control_supervisor_test
`default_nettype wire
